// ### bench/lhg_host.sv
module lhg_host (
  input wire logic hclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic low_power_req,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = lhg_pkg::HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    low_power_req = 1'b0;
  end
  task lp(input logic v);
    low_power_req <= v;
  endtask
  // One single transfer, entered just after a rising edge
  task xfer(input logic w, input logic [31:0] a, d,
    output logic [31:0] q, output bit to);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= lhg_pkg::HTRANS_NONSEQ;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= lhg_pkg::HTRANS_IDLE;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    q = hrdata;
    to = n >= 50;
  endtask
endmodule // lhg_host

// ### bench/lhg_int_cfg_bench.sv
module lhg_int_cfg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4;
  logic hclk, hresetn, hsel, hwrite, hrdy, hresp, acc_valid, lpr, lpe;
  logic low_act, high_act, irq, to;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [15:0] fx, fyz, px;
  logic [7:0] seed;
  int errors, samples_checked, n, mdl[int];
  int tbl[14][6] = '{'{0,0,0,2,255,1}, '{0,0,0,2,256,0}, '{0,1,0,2,127,1},
    '{0,1,0,2,128,0}, '{0,0,4,2,85,1}, '{0,0,4,2,86,0}, '{0,0,0,0,63,1},
    '{0,0,0,0,64,0}, '{1,0,0,2,257,1}, '{1,0,0,2,256,0}, '{1,0,0,0,65,1},
    '{1,0,0,0,64,0}, '{1,1,0,2,257,1}, '{1,0,0,2,-257,1}};
  lhg_host host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .low_power_req(lpr),
    .hready(hrdy), .hrdata(hrdata));
  lhg_int_cfg #(.TICK_CYCLES(T)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hresp), .hrdata(hrdata), .acc_valid(acc_valid),
    .acc_filt_x(fx), .acc_filt_y(fyz), .acc_filt_z(fyz), .acc_pre_x(px),
    .acc_pre_y(px), .acc_pre_z(px), .low_power_req(lpr),
    .low_power_en(lpe), .low_g_active(low_act), .high_g_active(high_act),
    .irq(irq));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  function logic [31:0] ad(input logic [9:0] i);
    return {20'h0, i, 2'h0};
  endfunction
  function logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task wrap_up;
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus transfer; writes update the register model
  task xfer(input logic w, input logic [31:0] a, d);
    host.xfer(w, a, d, q, to);
    if (to)
    begin
      errors++;
      wrap_up();
    end
    if (w)
      mdl[a] = (a == ad(lhg_pkg::IDX_MODE)) ? d & 32'hc7 : d & 32'hff;
  endtask
  task rd(input logic [31:0] a, exp);
    xfer(1'b0, a, 32'h0);
    cmp(q, exp);
  endtask
  task smp(input logic [15:0] x, yz, p);
    fx <= x;
    fyz <= yz;
    px <= p;
    acc_valid <= 1'b1;
    @(posedge hclk);
    acc_valid <= 1'b0;
  endtask
  // One sample, then the selected event output after it settles
  task hys(input logic [15:0] x, yz, input logic h, e);
    smp(x, yz, 16'h0);
    repeat (8) @(posedge hclk);
    cmp({31'h0, h ? high_act : low_act}, {31'h0, e});
  endtask
  initial
  begin
    hresetn = 1'b0;
    acc_valid = 1'b0;
    {fx, fyz, px} = '0;
    errors = 0;
    samples_checked = 0;
    seed = 8'h32;
    mdl[ad(lhg_pkg::IDX_LOW_DUR)] = lhg_pkg::RST_LOW_DUR;
    mdl[ad(lhg_pkg::IDX_LOW_TH)] = lhg_pkg::RST_LOW_TH;
    mdl[ad(lhg_pkg::IDX_MODE)] = lhg_pkg::RST_MODE;
    mdl[ad(lhg_pkg::IDX_HIGH_DUR)] = lhg_pkg::RST_HIGH_DUR;
    mdl[ad(lhg_pkg::IDX_HIGH_TH)] = lhg_pkg::RST_HIGH_TH;
    mdl[ad(lhg_pkg::IDX_SRC)] = 0;
    mdl[ad(lhg_pkg::IDX_EN)] = 0;
    mdl[ad(lhg_pkg::IDX_RANGE)] = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (mdl[a])
      rd(a, mdl[a]);
    foreach (mdl[a])
      if (a > ad(lhg_pkg::IDX_SRC) && a < ad(lhg_pkg::IDX_STAT))
      begin
        seed = nxt(seed);
        xfer(1'b1, a, {24'hffffff, seed});
        rd(a, mdl[a]);
      end
    xfer(1'b1, ad(lhg_pkg::IDX_STAT), 32'h3);
    rd(ad(lhg_pkg::IDX_STAT), 32'h0);
    xfer(1'b1, 32'h1d0, 32'h5a);
    rd(32'h1d0, 32'h0);
    xfer(1'b1, ad(lhg_pkg::IDX_RANGE), 32'h0);
    xfer(1'b1, ad(lhg_pkg::IDX_MODE), 32'h0);
    xfer(1'b1, ad(lhg_pkg::IDX_LOW_TH), 32'h2);
    xfer(1'b1, ad(lhg_pkg::IDX_HIGH_TH), 32'hff);
    for (int c = 0; c < 4; c += 3)
    begin
      xfer(1'b1, ad(lhg_pkg::IDX_EN), 32'h0);
      xfer(1'b1, ad(lhg_pkg::IDX_LOW_DUR), 32'(c));
      smp(16'h4000, 16'h4000, 16'h0);
      repeat (4) @(posedge hclk);
      xfer(1'b1, ad(lhg_pkg::IDX_CLR), 32'h3);
      smp(16'h0, 16'h0, 16'h0);
      n = 0;
      while (low_act !== 1'b1 && n < 200)
      begin
        @(posedge hclk);
        n++;
      end
      cmp(32'(n), 32'((c + 1) * T + 1));
      repeat (2) @(posedge hclk);
      rd(ad(lhg_pkg::IDX_STAT), 32'h1);
      cmp({31'h0, irq}, 32'h0);
      xfer(1'b1, ad(lhg_pkg::IDX_EN), 32'h3);
      repeat (2) @(posedge hclk);
      cmp({31'h0, irq}, 32'h1);
      xfer(1'b1, ad(lhg_pkg::IDX_CLR), 32'h1);
      repeat (2) @(posedge hclk);
      cmp({31'h0, irq}, 32'h0);
      rd(ad(lhg_pkg::IDX_STAT), 32'h0);
    end
    xfer(1'b1, ad(lhg_pkg::IDX_HIGH_DUR), 32'h0);
    xfer(1'b1, ad(lhg_pkg::IDX_LOW_DUR), 32'h0);
    foreach (tbl[i])
    begin
      xfer(1'b1, ad(lhg_pkg::IDX_RANGE), 32'(tbl[i][1]));
      xfer(1'b1, ad(lhg_pkg::IDX_MODE), 32'(tbl[i][2]));
      xfer(1'b1, ad(lhg_pkg::IDX_LOW_TH), 32'(tbl[i][3]));
      xfer(1'b1, ad(lhg_pkg::IDX_HIGH_TH), 32'(tbl[i][3]));
      smp(tbl[i][0] ? 16'h0 : 16'h4000, tbl[i][0] ? 16'h0 : 16'h4000,
        16'h0);
      repeat (4) @(posedge hclk);
      smp(16'(tbl[i][4]), tbl[i][0] ? 16'h0 : 16'(tbl[i][4]), 16'h0);
      repeat (8) @(posedge hclk);
      cmp(tbl[i][0] ? high_act : low_act, 32'(tbl[i][5]));
    end
    // Bands at 4 g: low 128 + 1024, high 4096 - 2048 sample LSBs
    xfer(1'b1, ad(lhg_pkg::IDX_RANGE), 32'h1);
    xfer(1'b1, ad(lhg_pkg::IDX_MODE), 32'h41);
    xfer(1'b1, ad(lhg_pkg::IDX_HIGH_TH), 32'h20);
    hys(16'h0, 16'h0, 1'b0, 1'b1);
    hys(16'h44c, 16'h44c, 1'b0, 1'b1);
    hys(16'h4b0, 16'h4b0, 1'b0, 1'b0);
    hys(16'h1001, 16'h0, 1'b1, 1'b1);
    hys(16'h801, 16'h0, 1'b1, 1'b1);
    hys(16'h800, 16'h0, 1'b1, 1'b0);
    xfer(1'b1, ad(lhg_pkg::IDX_RANGE), 32'h0);
    xfer(1'b1, ad(lhg_pkg::IDX_LOW_TH), 32'h2);
    xfer(1'b1, ad(lhg_pkg::IDX_SRC), 32'h80);
    smp(16'h4000, 16'h4000, 16'h0);
    repeat (8) @(posedge hclk);
    cmp({31'h0, low_act}, 32'h1);
    host.lp(1'b1);
    repeat (3) @(posedge hclk);
    cmp({31'h0, lpe}, 32'h0);
    xfer(1'b1, ad(lhg_pkg::IDX_SRC), 32'h0);
    repeat (3) @(posedge hclk);
    cmp({31'h0, lpe}, 32'h1);
    wrap_up();
  end
endmodule // lhg_int_cfg_bench

// ### bench/lhg_int_cfg_properties.sv
module lhg_int_cfg_properties #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic acc_valid,
  input wire logic low_power_req,
  input wire logic low_power_en,
  input wire logic low_g_active,
  input wire logic high_g_active,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] wr_age_r;
  // Cycles since the last write address phase, saturating
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_age_r <= 4'hf;
    else if (hsel && hready && htrans[1] && hwrite)
      wr_age_r <= 4'h0;
    else if (wr_age_r != 4'hf)
      wr_age_r <= wr_age_r + 4'h1;
  end
  okay_resp_a:
    assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus response not OKAY and ready");
  rdata_upper_a:
    assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rdata_hold_a:
    assert property (!$past(hsel && hready && htrans[1] && !hwrite)
      |-> $stable(hrdata)) else $error("read data moved without a read");
  low_power_a:
    assert property (low_power_en |-> $past(low_power_req))
    else $error("low power entered without request");
  low_fall_a:
    assert property ($fell(low_g_active) |-> $past(acc_valid)
      || $past(acc_valid, 2) || $past(acc_valid, 3))
    else $error("low-g event dropped without a sample");
  high_fall_a:
    assert property ($fell(high_g_active) |-> $past(acc_valid)
      || $past(acc_valid, 2) || $past(acc_valid, 3))
    else $error("high-g event dropped without a sample");
  irq_fall_a:
    assert property ($fell(irq) |-> wr_age_r < 4'h6)
    else $error("interrupt dropped without a write");
  irq_rise_a:
    assert property ($rose(irq) |-> wr_age_r < 4'h6
      || $past(low_g_active || high_g_active)
      || $past(low_g_active || high_g_active, 2))
    else $error("interrupt raised without cause");
  low_seen_c: cover property ($rose(low_g_active));
endmodule // lhg_int_cfg_properties

bind lhg_int_cfg lhg_int_cfg_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .acc_valid(acc_valid), .low_power_req(low_power_req),
  .low_power_en(low_power_en), .low_g_active(low_g_active),
  .high_g_active(high_g_active), .irq(irq));

// ### design/lhg_dwell.sv
module lhg_dwell #(
  parameter int TICK_CYCLES = lhg_pkg::DELAY_STEP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cond,
  input wire logic [7:0] dur_code,
  output logic active
);
  logic [lhg_pkg::TICK_W-1:0] pre_r;
  logic [lhg_pkg::DWELL_W-1:0] steps_r;
  logic [lhg_pkg::DWELL_W-1:0] target;
  logic step_done;

  assign target = {1'b0, dur_code} + 9'h001;
  assign step_done =
    (pre_r == lhg_pkg::TICK_W'(TICK_CYCLES - 1));

  // Step prescaler restarts whenever the condition drops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_r <= '0;
    else if (!cond || active || step_done)
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      steps_r <= '0;
    else if (!cond || active)
      steps_r <= '0;
    else if (step_done)
      steps_r <= steps_r + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      active <= 1'b0;
    else if (!cond)
      active <= 1'b0;
    else if (step_done && (steps_r + 1'b1 == target))
      active <= 1'b1;
  end
endmodule // lhg_dwell

// ### design/lhg_int_cfg.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
module lhg_int_cfg #(
  parameter int TICK_CYCLES = lhg_pkg::DELAY_STEP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic acc_valid,
  input wire logic [15:0] acc_filt_x,
  input wire logic [15:0] acc_filt_y,
  input wire logic [15:0] acc_filt_z,
  input wire logic [15:0] acc_pre_x,
  input wire logic [15:0] acc_pre_y,
  input wire logic [15:0] acc_pre_z,
  input wire logic low_power_req,
  output logic low_power_en,
  output logic low_g_active,
  output logic high_g_active,
  output logic irq
);
  logic [7:0] low_dur_r;
  logic [7:0] low_th_r;
  logic [7:0] mode_r;
  logic [7:0] high_dur_r;
  logic [7:0] high_th_r;
  logic src_r;
  logic [lhg_pkg::RANGE_W-1:0] range_r;
  logic [lhg_pkg::EV_W-1:0] stat_r;
  logic [lhg_pkg::EV_W-1:0] stat_nxt;
  logic [lhg_pkg::EV_W-1:0] en_r;
  logic [lhg_pkg::EV_W-1:0] clr_mask;
  logic [lhg_pkg::EV_W-1:0] act;
  logic [lhg_pkg::EV_W-1:0] act_d_r;
  logic [lhg_pkg::EV_W-1:0] cond_r;
  logic [lhg_pkg::EV_W-1:0] cond_nxt;
  logic [7:0] dur [lhg_pkg::EV_W];
  logic hreadyout_r;
  logic hresp_r;
  logic [31:0] hrdata_r;
  logic irq_r;
  logic low_power_en_r;

  // Bus address phase capture
  logic addr_take;
  logic addr_ok;
  logic [9:0] addr_idx;
  logic wr_pend_r;
  logic [9:0] wr_idx_r;
  logic [7:0] wdat;
  logic [7:0] rd_val;

  assign addr_take = hsel && hready && htrans[1];
  assign addr_ok = (haddr[31:12] == 20'h00000) &&
    (haddr[1:0] == 2'h0);
  assign addr_idx = haddr[11:2];
  assign wdat = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_pend_r <= 1'b0;
    else if (hready)
      wr_pend_r <= addr_take && hwrite && addr_ok;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_idx_r <= '0;
    else if (addr_take)
      wr_idx_r <= addr_idx;
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
    else
    begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  // Read mux; unmapped words read zero
  always_comb
  begin
    rd_val = 8'h00;
    if (!addr_ok)
      rd_val = 8'h00;
    else if (addr_idx == lhg_pkg::IDX_LOW_DUR)
      rd_val = low_dur_r;
    else if (addr_idx == lhg_pkg::IDX_LOW_TH)
      rd_val = low_th_r;
    else if (addr_idx == lhg_pkg::IDX_MODE)
      rd_val = mode_r & lhg_pkg::MODE_WR_MASK;
    else if (addr_idx == lhg_pkg::IDX_HIGH_DUR)
      rd_val = high_dur_r;
    else if (addr_idx == lhg_pkg::IDX_HIGH_TH)
      rd_val = high_th_r;
    else if (addr_idx == lhg_pkg::IDX_SRC)
      rd_val = {src_r, 7'h00};
    else if (addr_idx == lhg_pkg::IDX_STAT)
      rd_val = {6'h00, stat_r};
    else if (addr_idx == lhg_pkg::IDX_EN)
      rd_val = {6'h00, en_r};
    else if (addr_idx == lhg_pkg::IDX_RANGE)
      rd_val = {6'h00, range_r};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= '0;
    else if (addr_take && !hwrite)
      hrdata_r <= {24'h000000, rd_val};
  end

  // Configuration registers
  // low-g delay reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_dur_r <= lhg_pkg::RST_LOW_DUR;
    else if (wr_pend_r && wr_idx_r == lhg_pkg::IDX_LOW_DUR)
      low_dur_r <= wdat;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_th_r <= lhg_pkg::RST_LOW_TH;
    else if (wr_pend_r && wr_idx_r == lhg_pkg::IDX_LOW_TH)
      low_th_r <= wdat;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode_r <= lhg_pkg::RST_MODE;
    else if (wr_pend_r && wr_idx_r == lhg_pkg::IDX_MODE)
      mode_r <= wdat & lhg_pkg::MODE_WR_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      high_dur_r <= lhg_pkg::RST_HIGH_DUR;
    else if (wr_pend_r && wr_idx_r == lhg_pkg::IDX_HIGH_DUR)
      high_dur_r <= wdat;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      high_th_r <= lhg_pkg::RST_HIGH_TH;
    else if (wr_pend_r && wr_idx_r == lhg_pkg::IDX_HIGH_TH)
      high_th_r <= wdat;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      src_r <= 1'b0;
    else if (wr_pend_r && wr_idx_r == lhg_pkg::IDX_SRC)
      src_r <= wdat[lhg_pkg::SRC_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      range_r <= '0;
    else if (wr_pend_r && wr_idx_r == lhg_pkg::IDX_RANGE)
      range_r <= wdat[lhg_pkg::RANGE_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      en_r <= '0;
    else if (wr_pend_r && wr_idx_r == lhg_pkg::IDX_EN)
      en_r <= wdat[lhg_pkg::EV_W-1:0];
  end

  // Sample source and magnitudes
  logic [15:0] smp [lhg_pkg::AXES];
  logic [15:0] mag [lhg_pkg::AXES];
  logic [17:0] mag_sum;

  assign smp[0] = src_r ? acc_pre_x : acc_filt_x;
  assign smp[1] = src_r ? acc_pre_y : acc_filt_y;
  assign smp[2] = src_r ? acc_pre_z : acc_filt_z;

  generate
    for (genvar i = 0; i < lhg_pkg::AXES; i++)
    begin : g_axis
      assign mag[i] = smp[i][15] ? 16'(-smp[i]) : smp[i];
    end
  endgenerate

  assign mag_sum = 18'(mag[0]) + 18'(mag[1]) + 18'(mag[2]);

  // Thresholds and hysteresis in sample LSBs
  logic [17:0] low_th_lsb;
  logic [17:0] low_hy_lsb;
  logic [17:0] high_th_lsb;
  logic [17:0] high_hy_lsb;
  logic [17:0] low_lim;
  logic [17:0] high_lim;
  logic [1:0] low_hy_code;
  logic [1:0] high_hy_code;

  assign low_hy_code = mode_r[lhg_pkg::MODE_LOW_HY_LSB +: 2];
  assign high_hy_code = mode_r[lhg_pkg::MODE_HIGH_HY_LSB +: 2];

  assign low_th_lsb = (low_th_r == 8'h00) ?
    (lhg_pkg::TH_ZERO_LSB >> range_r) :
    (18'(18'(low_th_r) * lhg_pkg::TH_STEP_LSB) >> range_r);
  assign low_hy_lsb =
    18'(18'(low_hy_code) * lhg_pkg::HY_STEP_LSB) >> range_r;
  assign high_th_lsb = (high_th_r == 8'h00) ? lhg_pkg::TH_ZERO_LSB :
    18'(18'(high_th_r) * lhg_pkg::TH_STEP_LSB);
  assign high_hy_lsb = 18'(18'(high_hy_code) * lhg_pkg::HY_STEP_LSB);

  // Once active, the event holds until the hysteresis band is left
  assign low_lim = act[lhg_pkg::EV_LOW] ?
    18'(low_th_lsb + low_hy_lsb) : low_th_lsb;
  assign high_lim = !act[lhg_pkg::EV_HIGH] ? high_th_lsb :
    (high_th_lsb > high_hy_lsb) ? 18'(high_th_lsb - high_hy_lsb) :
    18'h00000;

  always_comb
  begin
    cond_nxt = '0;
    if (mode_r[lhg_pkg::MODE_LOW_MODE_BIT])
      cond_nxt[lhg_pkg::EV_LOW] = mag_sum < low_lim;
    else
      cond_nxt[lhg_pkg::EV_LOW] = (18'(mag[0]) < low_lim) &&
        (18'(mag[1]) < low_lim) && (18'(mag[2]) < low_lim);
    cond_nxt[lhg_pkg::EV_HIGH] = (18'(mag[0]) > high_lim) ||
      (18'(mag[1]) > high_lim) || (18'(mag[2]) > high_lim);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cond_r <= '0;
    else if (acc_valid)
      cond_r <= cond_nxt;
  end

  assign dur[lhg_pkg::EV_LOW] = low_dur_r;
  assign dur[lhg_pkg::EV_HIGH] = high_dur_r;

  generate
    for (genvar e = 0; e < lhg_pkg::EV_W; e++)
    begin : g_event
      lhg_dwell #(
        .TICK_CYCLES(TICK_CYCLES)
      ) u_dwell (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond(cond_r[e]),
        .dur_code(dur[e]),
        .active(act[e])
      );
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      act_d_r <= '0;
    else
      act_d_r <= act;
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_comb
  begin
    clr_mask = '0;
    if (wr_pend_r && wr_idx_r == lhg_pkg::IDX_CLR)
      clr_mask = wdat[lhg_pkg::EV_W-1:0];
    stat_nxt = (stat_r & ~clr_mask) | (act & ~act_d_r);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat_r <= '0;
    else
      stat_r <= stat_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(stat_nxt & en_r);
  end

  // no low power with pre-filtered source
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_power_en_r <= 1'b0;
    else
      low_power_en_r <= low_power_req && !src_r;
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign irq = irq_r;
  assign low_power_en = low_power_en_r;
  assign low_g_active = act[lhg_pkg::EV_LOW];
  assign high_g_active = act[lhg_pkg::EV_HIGH];
endmodule // lhg_int_cfg

// ### design/lhg_pkg.sv
// Operation
// - Low-g delay is (delay code + 1) times 2.5 ms, 2.5 to 640 ms.
// - Low-g delay code resets to the value giving 20 ms.
// - Low-g threshold is code times 7.81 mg, or 3.91 mg for code zero.
// - Low-g threshold spans 3.91 mg to 2 g, reset code gives 375 mg.
// - High-g hysteresis is code times 125/250/500/1000 mg per range.
// - Low-g mode bit: 0 single-axis, 1 axis-summing evaluation.
// - Low-g hysteresis is code times 125 mg in every range.
// - High-g delay is (code + 1) times 2.5 ms, reset gives 30 ms.
// - Pre-filtered source selected blocks entry into low-power mode.
// - High-g threshold is code times 7.81/15.63/31.25/62.5 mg per range.
// - Zero high-g code gives 3.91/7.81/15.63/31.25 mg per range.
// - Source bit: 0 feeds filtered data, 1 pre-filtered data.
package lhg_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [9:0] IDX_SRC = 10'h058;
  localparam logic [9:0] IDX_LOW_DUR = 10'h05a;
  localparam logic [9:0] IDX_LOW_TH = 10'h05b;
  localparam logic [9:0] IDX_MODE = 10'h05c;
  localparam logic [9:0] IDX_HIGH_DUR = 10'h05d;
  localparam logic [9:0] IDX_HIGH_TH = 10'h05e;
  localparam logic [9:0] IDX_STAT = 10'h070;
  localparam logic [9:0] IDX_CLR = 10'h071;
  localparam logic [9:0] IDX_EN = 10'h072;
  localparam logic [9:0] IDX_RANGE = 10'h073;

  // Values after reset
  localparam logic [7:0] RST_LOW_DUR = 8'h07;
  localparam logic [7:0] RST_LOW_TH = 8'h30;
  localparam logic [7:0] RST_MODE = 8'h81;
  localparam logic [7:0] RST_HIGH_DUR = 8'h0b;
  localparam logic [7:0] RST_HIGH_TH = 8'hc0;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Field layout
  localparam logic [7:0] MODE_WR_MASK = 8'hc7;
  localparam int MODE_HIGH_HY_LSB = 6;
  localparam int MODE_LOW_MODE_BIT = 2;
  localparam int MODE_LOW_HY_LSB = 0;
  localparam int SRC_BIT = 7;
  localparam int RANGE_W = 2;

  // Event bits in status, clear and enable registers
  localparam int EV_LOW = 0;
  localparam int EV_HIGH = 1;
  localparam int EV_W = 2;
  localparam int AXES = 3;

  // Magnitudes in sample LSBs at 2 g full scale over 16 bits:
  // 7.81 mg = 128, 3.91 mg = 64, 125 mg = 2048; each wider range
  // doubles the mg per LSB, so fixed-mg values shift right by range.
  localparam int MAG_W = 18;
  localparam logic [17:0] TH_STEP_LSB = 18'h00080;
  localparam logic [17:0] TH_ZERO_LSB = 18'h00040;
  localparam logic [17:0] HY_STEP_LSB = 18'h00800;

  // Delay step time
  localparam real DELAY_STEP_MS = 2.5;
  localparam real CLK_PERIOD_NS = 5.0;
  localparam int DELAY_STEP_CYC =
    int'(DELAY_STEP_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int TICK_W = 20;
  localparam int DWELL_W = 9;

  // AHB-Lite
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
